// ### iudc_pkg.sv
// shared constants and types for the disk channel handshake block
package iudc_pkg;
  localparam int NUM_CH = 2; // primary is index 0, secondary index 1
  localparam int DATA_W = 16; // disk data bus width
  localparam int REF_CLK_MHZ = 20; // REF_CLK rate
  localparam int PIO_MIN_NS = 120; // least strobe time of a conventional cycle
  localparam int ARM_MIN_NS = 100; // least stop-asserted time before data
  localparam int TERM_MIN_NS = 100; // least stop-asserted time before release
  // least times round up to whole cycles
  localparam int PIO_CYC = (PIO_MIN_NS * REF_CLK_MHZ + 999) / 1000;
  localparam int ARM_CYC = (ARM_MIN_NS * REF_CLK_MHZ + 999) / 1000;
  localparam int TERM_CYC = (TERM_MIN_NS * REF_CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 4; // wide enough for every count above
  localparam logic [CNT_W-1:0] PIO_LOAD = CNT_W'(PIO_CYC - 1);
  localparam logic [CNT_W-1:0] ARM_LOAD = CNT_W'(ARM_CYC - 1);
  localparam logic [CNT_W-1:0] TERM_LOAD = CNT_W'(TERM_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
  // per-channel sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_PIO = 5'b00010,
    ST_ARM = 5'b00100,
    ST_DATA = 5'b01000,
    ST_TERM = 5'b10000
  } iudc_state_t;
endpackage

// ### iudc_buf2.sv
// two-entry valid/ready buffer with registered read data
`timescale 1ns/1ps
module iudc_buf2
  #(parameter int W = 16)
  (
  input wire logic clk, // REF_CLK
  input wire logic rst, // synchronous, active high
  input wire logic ce, // freezes all state while low
  input wire logic in_valid, // word offered
  output logic in_ready, // room for a word
  input wire logic [W-1:0] in_data, // word in
  output logic out_valid, // word held
  input wire logic out_ready, // consumer takes word
  output logic [W-1:0] out_data // oldest word, from a register
  );
  typedef struct packed {
    logic [1:0][W-1:0] mem;
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] cnt;
  } iudc_buf_t;
  iudc_buf_t r, n;
  logic push, pop;

  // handshakes come straight from the count so back-pressure is exact
  assign in_ready = (r.cnt != 2'h2);
  assign out_valid = (r.cnt != 2'h0);
  assign out_data = r.mem[r.rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // next state
  always_comb
  begin
    n = r;
    if (push)
    begin
      n.mem[r.wr_ptr] = in_data;
      n.wr_ptr = ~r.wr_ptr;
    end
    if (pop)
      n.rd_ptr = ~r.rd_ptr;
    if (push && !pop)
      n.cnt = r.cnt + 2'h1;
    else if (pop && !push)
      n.cnt = r.cnt - 2'h1;
  end

  // state register
  always_ff @(posedge clk)
  begin
    if (rst)
      r <= '0;
    else if (ce)
      r <= n;
  end
endmodule // iudc_buf2

// ### iudc_top.sv
// two-channel disk handshake: conventional ready wait and burst flow control
`timescale 1ns/1ps
module iudc_top
  import iudc_pkg::*;
  (
  input wire logic REF_CLK, // block clock, 20 MHz
  input wire logic RST, // synchronous reset, active high
  input wire logic CE, // clock enable, freezes state when low
  // drive side pins
  output logic PRI_BURST_STOP, // primary stop line
  output logic SEC_BURST_STOP, // secondary stop line
  input wire logic PRI_DRIVE_READY, // primary ready / flow / strobe pin
  input wire logic SEC_DRIVE_READY, // secondary ready / flow / strobe pin
  output logic PRI_HOST_DMA_FLOW, // primary host pause during reads
  output logic SEC_HOST_DMA_FLOW, // secondary host pause during reads
  output logic PRI_HOST_DATA_STROBE, // primary strobe during writes
  output logic SEC_HOST_DATA_STROBE, // secondary strobe during writes
  input wire logic PRI_DMA_REQUEST, // primary drive request
  input wire logic SEC_DMA_REQUEST, // secondary drive request
  output logic PRI_DMA_ACKNOWLEDGE, // primary acknowledge
  output logic SEC_DMA_ACKNOWLEDGE, // secondary acknowledge
  input wire logic [DATA_W-1:0] PRI_DISK_DATA_IN, // primary data bus, read
  output logic [DATA_W-1:0] PRI_DISK_DATA_OUT, // primary data bus, driven
  output logic PRI_DISK_DATA_OE, // primary data bus enable
  input wire logic [DATA_W-1:0] SEC_DISK_DATA_IN, // secondary data bus, read
  output logic [DATA_W-1:0] SEC_DISK_DATA_OUT, // secondary data bus, driven
  output logic SEC_DISK_DATA_OE, // secondary data bus enable
  input wire logic MASTER_CYCLE, // bus-master cycle indicator pin
  output logic ADDR_XCVR_OUT_ENABLE, // transceiver output enable, high on
  output logic XCVR_DIR_SYS_TO_DISK, // transceiver direction
  // controller side, index 0 primary, 1 secondary
  input wire logic XCVR_ENABLE, // core wants the transceiver open
  input wire logic [NUM_CH-1:0] CH_UDMA_MODE, // burst mode select
  input wire logic [NUM_CH-1:0] CH_CYC_REQ, // conventional cycle start pulse
  input wire logic [NUM_CH-1:0] CH_CYC_WRITE, // conventional cycle drives data
  input wire logic [NUM_CH-1:0][DATA_W-1:0] CH_CYC_WDATA, // conventional write word
  output logic [NUM_CH-1:0] CH_CYC_DONE, // conventional cycle end pulse
  output logic [NUM_CH-1:0][DATA_W-1:0] CH_CYC_RDATA, // conventional read word
  input wire logic [NUM_CH-1:0] CH_BURST_GO, // start burst when drive requests
  input wire logic [NUM_CH-1:0] CH_BURST_WRITE, // burst direction, high writes
  input wire logic [NUM_CH-1:0] CH_BURST_END, // ask to end the burst
  output logic [NUM_CH-1:0] CH_BUSY, // channel sequencer not idle
  input wire logic [NUM_CH-1:0] CH_TX_VALID, // write word offered
  output logic [NUM_CH-1:0] CH_TX_READY, // write word taken
  input wire logic [NUM_CH-1:0][DATA_W-1:0] CH_TX_DATA, // write word
  output logic [NUM_CH-1:0] CH_RX_VALID, // read word available
  input wire logic [NUM_CH-1:0] CH_RX_READY, // core takes read word
  output logic [NUM_CH-1:0][DATA_W-1:0] CH_RX_DATA // read word
  );
  typedef struct packed {
    iudc_state_t [NUM_CH-1:0] st;
    logic [NUM_CH-1:0][CNT_W-1:0] cnt;
    logic [NUM_CH-1:0] wr;
    logic [NUM_CH-1:0] rdy_s1;
    logic [NUM_CH-1:0] rdy_s2;
    logic [NUM_CH-1:0] rdy_s3;
    logic [NUM_CH-1:0] req_s1;
    logic [NUM_CH-1:0] req_s2;
    logic [NUM_CH-1:0][DATA_W-1:0] dat_s1;
    logic [NUM_CH-1:0][DATA_W-1:0] dat_s2;
    logic master_s1;
    logic master_s2;
    logic [NUM_CH-1:0] stop;
    logic [NUM_CH-1:0] ack;
    logic [NUM_CH-1:0] hflow;
    logic [NUM_CH-1:0] hstrb;
    logic [NUM_CH-1:0] oe;
    logic [NUM_CH-1:0][DATA_W-1:0] dout;
    logic [NUM_CH-1:0] done;
    logic [NUM_CH-1:0][DATA_W-1:0] rdata;
    logic [NUM_CH-1:0] push;
    logic [NUM_CH-1:0][DATA_W-1:0] pdat;
    logic xoe;
    logic xdir;
  } iudc_regs_t;
  iudc_regs_t r, n;
  logic [NUM_CH-1:0] rdy_pin, req_pin, buf_in_ready;
  logic [NUM_CH-1:0][DATA_W-1:0] din_pin;

  // gather the two channels' pins into vectors
  assign rdy_pin = {SEC_DRIVE_READY, PRI_DRIVE_READY};
  assign req_pin = {SEC_DMA_REQUEST, PRI_DMA_REQUEST};
  assign din_pin = {SEC_DISK_DATA_IN, PRI_DISK_DATA_IN};

  // write words are pulled only while the drive lets strobes run
  always_comb
  begin
    for (int ch = 0; ch < NUM_CH; ch++)
      CH_TX_READY[ch] = CE && (r.st[ch] == ST_DATA) && r.wr[ch]
        && !r.rdy_s2[ch] && !r.stop[ch];
  end

  // per-channel sequencers, one loop so both channels behave alike
  always_comb
  begin
    logic strobe_edge;
    logic end_ask;
    strobe_edge = 1'b0;
    end_ask = 1'b0;
    n = r;
    n.master_s1 = MASTER_CYCLE;
    n.master_s2 = r.master_s1;
    n.xdir = r.master_s2;
    n.xoe = XCVR_ENABLE && (r.oe == '0);
    for (int ch = 0; ch < NUM_CH; ch++)
    begin
      // every pin passes two flops before use; s3 only finds edges
      n.rdy_s1[ch] = rdy_pin[ch];
      n.rdy_s2[ch] = r.rdy_s1[ch];
      n.rdy_s3[ch] = r.rdy_s2[ch];
      n.req_s1[ch] = req_pin[ch];
      n.req_s2[ch] = r.req_s1[ch];
      n.dat_s1[ch] = din_pin[ch];
      n.dat_s2[ch] = r.dat_s1[ch];
      n.done[ch] = 1'b0;
      n.push[ch] = 1'b0;
      strobe_edge = r.rdy_s2[ch] ^ r.rdy_s3[ch];
      end_ask = CH_BURST_END[ch] || !r.req_s2[ch];
      // read bursts: the pin is the drive strobe, either edge carries a word
      if (!r.wr[ch] && ((r.st[ch] == ST_DATA) || (r.st[ch] == ST_TERM)))
      begin
        n.push[ch] = strobe_edge;
        n.pdat[ch] = r.dat_s2[ch];
      end
      // pause early: the drive needs time to see the pause, so hold it
      // whenever any word waits, the spare entry absorbs the lag
      n.hflow[ch] = !r.wr[ch] && ((r.st[ch] == ST_DATA) || (r.st[ch] == ST_TERM))
        && (CH_RX_VALID[ch] || !buf_in_ready[ch]);
      unique case (r.st[ch])
        ST_IDLE:
        begin
          if (CH_CYC_REQ[ch] && !CH_UDMA_MODE[ch])
          begin
            n.st[ch] = ST_PIO;
            n.cnt[ch] = PIO_LOAD;
            n.wr[ch] = CH_CYC_WRITE[ch];
            n.oe[ch] = CH_CYC_WRITE[ch];
            n.dout[ch] = CH_CYC_WDATA[ch];
          end
          else if (CH_BURST_GO[ch] && CH_UDMA_MODE[ch] && r.req_s2[ch])
          begin
            n.st[ch] = ST_ARM;
            n.cnt[ch] = ARM_LOAD;
            n.wr[ch] = CH_BURST_WRITE[ch];
            n.stop[ch] = 1'b1;
            n.ack[ch] = 1'b1;
            n.oe[ch] = CH_BURST_WRITE[ch];
          end
        end
        ST_PIO:
        begin
          // minimum strobe time first, then wait out a not-ready drive
          if (r.cnt[ch] != CNT_ZERO)
            n.cnt[ch] = r.cnt[ch] - 4'h1;
          else if (r.rdy_s2[ch])
          begin
            n.st[ch] = ST_IDLE;
            n.done[ch] = 1'b1;
            n.oe[ch] = 1'b0;
            n.rdata[ch] = r.dat_s2[ch];
          end
        end
        ST_ARM:
        begin
          if (r.cnt[ch] != CNT_ZERO)
            n.cnt[ch] = r.cnt[ch] - 4'h1;
          else
          begin
            n.st[ch] = ST_DATA;
            n.stop[ch] = 1'b0;
          end
        end
        ST_DATA:
        begin
          if (CH_TX_READY[ch] && CH_TX_VALID[ch])
          begin
            n.dout[ch] = CH_TX_DATA[ch];
            n.hstrb[ch] = ~r.hstrb[ch];
          end
          if (end_ask)
          begin
            n.st[ch] = ST_TERM;
            n.cnt[ch] = TERM_LOAD;
            n.stop[ch] = 1'b1;
          end
        end
        ST_TERM:
        begin
          // stop is held; late read strobes are still caught above
          if (r.cnt[ch] != CNT_ZERO)
            n.cnt[ch] = r.cnt[ch] - 4'h1;
          else
          begin
            n.st[ch] = ST_IDLE;
            n.stop[ch] = 1'b0;
            n.ack[ch] = 1'b0;
            n.oe[ch] = 1'b0;
          end
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      r <= '0;
      // enum elements get their own idle code, not a raw vector
      for (int ch = 0; ch < NUM_CH; ch++)
        r.st[ch] <= ST_IDLE;
    end
    else if (CE)
      r <= n;
  end

  // read words go through a two-entry buffer so a stalled core loses none
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++)
    begin : g_rx
      iudc_buf2 #(.W(DATA_W)) u_rxbuf (
        .clk(REF_CLK),
        .rst(RST),
        .ce(CE),
        .in_valid(r.push[g]),
        .in_ready(buf_in_ready[g]),
        .in_data(r.pdat[g]),
        .out_valid(CH_RX_VALID[g]),
        .out_ready(CH_RX_READY[g]),
        .out_data(CH_RX_DATA[g])
      );
    end
  endgenerate

  // pin and core outputs, all from flops
  assign PRI_BURST_STOP = r.stop[0];
  assign SEC_BURST_STOP = r.stop[1];
  assign PRI_HOST_DMA_FLOW = r.hflow[0];
  assign SEC_HOST_DMA_FLOW = r.hflow[1];
  assign PRI_HOST_DATA_STROBE = r.hstrb[0];
  assign SEC_HOST_DATA_STROBE = r.hstrb[1];
  assign PRI_DMA_ACKNOWLEDGE = r.ack[0];
  assign SEC_DMA_ACKNOWLEDGE = r.ack[1];
  assign PRI_DISK_DATA_OUT = r.dout[0];
  assign SEC_DISK_DATA_OUT = r.dout[1];
  assign PRI_DISK_DATA_OE = r.oe[0];
  assign SEC_DISK_DATA_OE = r.oe[1];
  assign ADDR_XCVR_OUT_ENABLE = r.xoe;
  assign XCVR_DIR_SYS_TO_DISK = r.xdir;
  assign CH_CYC_DONE = r.done;
  assign CH_CYC_RDATA = r.rdata;
  always_comb
  begin
    for (int ch = 0; ch < NUM_CH; ch++)
      CH_BUSY[ch] = (r.st[ch] != ST_IDLE);
  end
endmodule // iudc_top

// ### iudc_chk_sva.sv
// checker of stop framing, flow pauses and transceiver control
`timescale 1ns/1ps
module iudc_chk
  import iudc_pkg::*;
  (
  input wire logic REF_CLK, // clock
  input wire logic RST, // reset
  input wire logic PRI_BURST_STOP, // stop
  input wire logic SEC_BURST_STOP, // stop
  input wire logic PRI_DRIVE_READY, // pin
  input wire logic PRI_HOST_DATA_STROBE, // strobe
  input wire logic PRI_DMA_ACKNOWLEDGE, // ack
  input wire logic SEC_DMA_ACKNOWLEDGE, // ack
  input wire logic [DATA_W-1:0] PRI_DISK_DATA_OUT, // data
  input wire logic PRI_DISK_DATA_OE, // enable
  input wire logic SEC_DISK_DATA_OE, // enable
  input wire logic MASTER_CYCLE, // pin
  input wire logic ADDR_XCVR_OUT_ENABLE, // enable
  input wire logic XCVR_DIR_SYS_TO_DISK, // direction
  input wire logic XCVR_ENABLE, // core enable
  input wire logic [NUM_CH-1:0] CH_CYC_DONE, // done
  input wire logic [NUM_CH-1:0] CH_TX_VALID, // valid
  input wire logic [NUM_CH-1:0] CH_TX_READY, // ready
  input wire logic [NUM_CH-1:0][DATA_W-1:0] CH_TX_DATA // data
  );
  // one domain, so clock and reset are given once
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  a_stop_arm_pri: assert property (
    $rose(PRI_DMA_ACKNOWLEDGE) |-> PRI_BURST_STOP[*2] ##1 !PRI_BURST_STOP)
    else $error("primary stop arm wrong");
  a_stop_arm_sec: assert property (
    $rose(SEC_DMA_ACKNOWLEDGE) |-> SEC_BURST_STOP[*2] ##1 !SEC_BURST_STOP)
    else $error("secondary stop arm wrong");
  a_stop_ends_burst: assert property (
    $fell(PRI_DMA_ACKNOWLEDGE) |-> $past(PRI_BURST_STOP, 2))
    else $error("burst ended without stop");
  a_flow_stalls_tx: assert property (PRI_DRIVE_READY[*3] |-> !CH_TX_READY[0])
    else $error("word taken during drive pause");
  a_strobe_on_take: assert property (
    $changed(PRI_HOST_DATA_STROBE) |-> $past(CH_TX_VALID[0] && CH_TX_READY[0]))
    else $error("strobe without word");
  a_word_on_take: assert property (
    CH_TX_VALID[0] && CH_TX_READY[0] |=> PRI_DISK_DATA_OUT == $past(CH_TX_DATA[0]))
    else $error("wrong word driven");
  a_ready_wait: assert property ((!PRI_DRIVE_READY)[*4] |-> !CH_CYC_DONE[0])
    else $error("cycle ended while not ready");
  a_xcvr_gate: assert property (
    !$past(RST) |-> ADDR_XCVR_OUT_ENABLE ==
      $past(XCVR_ENABLE && !PRI_DISK_DATA_OE && !SEC_DISK_DATA_OE))
    else $error("transceiver enable wrong");
  a_dir_follow: assert property (
    !$past(RST) && !$past(RST, 2) && !$past(RST, 3) |->
      XCVR_DIR_SYS_TO_DISK == $past(MASTER_CYCLE, 3))
    else $error("direction not following");
endmodule // iudc_chk
bind iudc_top iudc_chk chk_u (.*);

// ### iudc_drive_model.sv
// behavioural disk drive for one channel cable
`timescale 1ns/1ps
module iudc_drive_model
  import iudc_pkg::*;
  #(parameter int NW = 6)
  (
  input wire logic clk, // REF_CLK
  input wire logic rst, // reset
  input wire logic ack, // host ack
  input wire logic stop, // host stop
  input wire logic host_flow, // host pause
  input wire logic rd_burst, // burst to host
  input wire logic busy_hold, // not ready or pause
  input wire logic want_req, // may request
  output logic ready_pin, // ready, flow or strobe
  output logic dma_req, // request
  output logic [DATA_W-1:0] data_pin // data to host
  );
  logic [1:0] ph_r;
  logic [3:0] sent_r;
  logic strb_r;
  logic go;
  logic [DATA_W-1:0] word;
  assign dma_req = want_req;
  assign go = ack && !stop && rd_burst && (sent_r < 4'(NW));
  assign word = 16'h5a00 | {12'h000, sent_r};
  // data steady two cycles round each strobe edge, inverted when idle
  assign data_pin = go ? word : ~word;
  // strobe moves only while neither side pauses
  always_ff @(posedge clk)
  begin
    // strobe rests at the ready level, so the change of pin meaning at
    // acknowledge makes no edge that the host would take for a word
    if (rst || !ack)
    begin
      ph_r <= 2'h0;
      sent_r <= 4'h0;
      strb_r <= 1'b1;
    end
    else if (go && !host_flow && !busy_hold)
    begin
      ph_r <= ph_r + 2'h1;
      if (ph_r == 2'h1) strb_r <= !strb_r;
      if (ph_r == 2'h3) sent_r <= sent_r + 4'h1;
    end
  end
  // one pin, three uses; a negated ready floats, shown as low
  always_comb
  begin
    if (ack && rd_burst) ready_pin = strb_r;
    else if (ack) ready_pin = busy_hold;
    else ready_pin = !busy_hold;
  end
endmodule // iudc_drive_model

// ### tb_ide_udma_channel_handshake.sv
// self-checking bench for the two-channel disk handshake block
`timescale 1ns/1ps
module tb_ide_udma_channel_handshake;
  import iudc_pkg::*;
  logic REF_CLK = 1'b0, RST = 1'b1, CE = 1'b1, MASTER_CYCLE = 1'b0, XCVR_ENABLE = 1'b0;
  logic [NUM_CH-1:0] CH_UDMA_MODE = '0, CH_CYC_REQ = '0, CH_CYC_WRITE = '0, CH_BURST_GO = '0;
  logic [NUM_CH-1:0] CH_BURST_WRITE = '0, CH_BURST_END = '0, CH_TX_VALID = '0, CH_RX_READY = '0;
  logic [NUM_CH-1:0][DATA_W-1:0] CH_CYC_WDATA = '0, CH_TX_DATA = '0, CH_CYC_RDATA, CH_RX_DATA;
  logic [NUM_CH-1:0] CH_CYC_DONE, CH_BUSY, CH_TX_READY, CH_RX_VALID, hold = '0, want = '0;
  logic [NUM_CH-1:0] rdb = '0, ps = '0;
  logic PRI_BURST_STOP, SEC_BURST_STOP, PRI_DRIVE_READY, SEC_DRIVE_READY, PRI_HOST_DMA_FLOW;
  logic SEC_HOST_DMA_FLOW, PRI_HOST_DATA_STROBE, SEC_HOST_DATA_STROBE, PRI_DMA_REQUEST;
  logic SEC_DMA_REQUEST, PRI_DMA_ACKNOWLEDGE, SEC_DMA_ACKNOWLEDGE, PRI_DISK_DATA_OE;
  logic SEC_DISK_DATA_OE, ADDR_XCVR_OUT_ENABLE, XCVR_DIR_SYS_TO_DISK;
  logic [DATA_W-1:0] PRI_DISK_DATA_IN, PRI_DISK_DATA_OUT, SEC_DISK_DATA_IN, SEC_DISK_DATA_OUT;
  logic [DATA_W-1:0] wq[$];
  int n_errors = 0;
  int tests_run = 0;
  iudc_top dut_u (.*);
  // one drive model per cable
  iudc_drive_model pri_u (.clk(REF_CLK), .rst(RST), .ack(PRI_DMA_ACKNOWLEDGE),
    .stop(PRI_BURST_STOP), .host_flow(PRI_HOST_DMA_FLOW), .rd_burst(rdb[0]), .busy_hold(hold[0]),
    .want_req(want[0]), .ready_pin(PRI_DRIVE_READY), .dma_req(PRI_DMA_REQUEST),
    .data_pin(PRI_DISK_DATA_IN));
  iudc_drive_model sec_u (.clk(REF_CLK), .rst(RST), .ack(SEC_DMA_ACKNOWLEDGE),
    .stop(SEC_BURST_STOP), .host_flow(SEC_HOST_DMA_FLOW), .rd_burst(rdb[1]), .busy_hold(hold[1]),
    .want_req(want[1]), .ready_pin(SEC_DRIVE_READY), .dma_req(SEC_DMA_REQUEST),
    .data_pin(SEC_DISK_DATA_IN));
  initial
  begin
    forever #25 REF_CLK = ~REF_CLK;
  end
  // log each word strobed out, on whichever channel moved
  always @(negedge REF_CLK)
  begin
    if (PRI_HOST_DATA_STROBE !== ps[0]) wq.push_back(PRI_DISK_DATA_OUT);
    if (SEC_HOST_DATA_STROBE !== ps[1]) wq.push_back(SEC_DISK_DATA_OUT);
    ps = {SEC_HOST_DATA_STROBE, PRI_HOST_DATA_STROBE};
  end
  task automatic tick(int n);
    repeat (n) @(negedge REF_CLK);
  endtask
  task automatic report_and_stop();
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(string what, logic [DATA_W-1:0] exp, logic [DATA_W-1:0] got);
    tests_run++;
    if (got !== exp)
    begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      n_errors++;
    end
  endtask
  // a hang counts as a mismatch and closes the run
  task automatic guard(int t);
    if (t > 400)
    begin
      n_errors++;
      report_and_stop();
    end
  endtask
  task automatic wait_sig(int s, int ch, logic v);
    int t;
    t = 0;
    while ((s ? CH_TX_READY[ch] : CH_BUSY[ch]) !== v)
    begin
      tick(1);
      t++;
      guard(t);
    end
  endtask
  task automatic conv_cycle(int ch, int h, logic wr);
    int t;
    t = 0;
    hold[ch] = (h > 0);
    CH_CYC_WRITE[ch] = wr;
    CH_CYC_WDATA[ch] = 16'h3c0f;
    CH_CYC_REQ[ch] = 1'b1;
    // a done pulse left from the cycle before must not end this one
    do
    begin
      tick(1);
      t++;
      CH_CYC_REQ[ch] = 1'b0;
      if (t == h) hold[ch] = 1'b0;
      if (t == 1 && wr) check("bus out", 16'h3c0f, ch ? SEC_DISK_DATA_OUT : PRI_DISK_DATA_OUT);
      guard(t);
    end while (CH_CYC_DONE[ch] !== 1'b1);
    check("cycle length", 1'b1, t >= (h ? h + 2 : 3) && t <= (h ? h + 4 : 4));
    if (!wr) check("read word", 16'ha5ff, CH_CYC_RDATA[ch]);
  endtask
  task automatic start_burst(int ch, logic wr);
    CH_UDMA_MODE[ch] = 1'b1;
    rdb[ch] = !wr;
    want[ch] = 1'b1;
    CH_BURST_WRITE[ch] = wr;
    CH_BURST_GO[ch] = 1'b1;
    wait_sig(0, ch, 1'b1);
    CH_BURST_GO[ch] = 1'b0;
  endtask
  task automatic end_burst(int ch);
    CH_BURST_END[ch] = 1'b1;
    want[ch] = 1'b0;
    wait_sig(0, ch, 1'b0);
    CH_BURST_END[ch] = 1'b0;
    CH_UDMA_MODE[ch] = 1'b0;
  endtask
  task automatic wr_burst(int ch);
    wq.delete();
    start_burst(ch, 1'b1);
    for (int i = 0; i < 6; i++)
    begin
      CH_TX_DATA[ch] = 16'(16'h1000 + i);
      if (i == 3)
      begin
        CH_TX_VALID[ch] = 1'b0;
        hold[ch] = 1'b1;
        tick(4);
        CH_TX_VALID[ch] = 1'b1;
        tick(6);
        check("paused", 1'b0, CH_TX_READY[ch]);
        check("held strobes", 16'h3, 16'(wq.size()));
        check("xcvr off", 1'b0, ADDR_XCVR_OUT_ENABLE);
        hold[ch] = 1'b0;
      end
      CH_TX_VALID[ch] = 1'b1;
      wait_sig(1, ch, 1'b1);
      tick(1);
    end
    CH_TX_VALID[ch] = 1'b0;
    end_burst(ch);
    check("words out", 16'h6, 16'(wq.size()));
    foreach (wq[i]) check("word out", 16'(16'h1000 + i), wq[i]);
  endtask
  task automatic rd_burst(int ch);
    int k;
    int t;
    k = 0;
    t = 0;
    start_burst(ch, 1'b0);
    tick(40);
    check("host pause", 1'b1, ch ? SEC_HOST_DMA_FLOW : PRI_HOST_DMA_FLOW);
    CH_RX_READY[ch] = 1'b1;
    // drain while the drive stops its strobe for a stretch
    while (k < 6)
    begin
      hold[ch] = (t >= 8 && t < 30);
      if (CH_RX_VALID[ch] === 1'b1)
      begin
        check("read word", 16'(16'h5a00 + k), CH_RX_DATA[ch]);
        k++;
      end
      tick(1);
      t++;
      guard(t);
    end
    hold[ch] = 1'b0;
    end_burst(ch);
    check("drained", 1'b0, CH_RX_VALID[ch]);
    CH_RX_READY[ch] = 1'b0;
  endtask
  task automatic xcvr_dir();
    XCVR_ENABLE = 1'b1;
    for (int v = 1; v >= 0; v--)
    begin
      MASTER_CYCLE = v[0];
      tick(5);
      check("direction", v[0], XCVR_DIR_SYS_TO_DISK);
      check("xcvr enable", 1'b1, ADDR_XCVR_OUT_ENABLE);
    end
  endtask
  // a low enable freezes the sequencer, so a request then is never taken
  task automatic ce_freeze();
    CE = 1'b0;
    CH_CYC_REQ[0] = 1'b1;
    tick(3);
    check("frozen busy", 1'b0, CH_BUSY[0]);
    CH_CYC_REQ[0] = 1'b0;
    CE = 1'b1;
    tick(2);
    check("idle after freeze", 1'b0, CH_BUSY[0]);
  endtask
  // main sequence, both channels through every transfer kind
  initial
  begin
    tick(8);
    RST = 1'b0;
    tick(2);
    xcvr_dir();
    ce_freeze();
    for (int c = 0; c < 2; c++)
    begin
      conv_cycle(c, 0, 1'b1);
      conv_cycle(c, 10, 1'b0);
      wr_burst(c);
      rd_burst(c);
    end
    report_and_stop();
  end
endmodule // tb_ide_udma_channel_handshake
